// [fapr_params.svh]
// Contract
// [R1] Boot block writable while serial programming active
// [R2] Boot block write-protected during self-programming
// [R3] Reading erased unprogrammed word flags ECC error
// [R4] Host blank check: data, ECC, parity ones
// [R5] Interrupted area undefined; host never reads it; FAPR_U_FWXFER still reads it
// [R6] No second program; host erases first
// [R7] After abnormal end host erases again
// [R8] Abnormal end locks block; erase unlocked
// [R9] Host holds high-voltage enables during operations
// [R10] Enable drop while busy flags high-voltage error
// [R11] Area select picks code or firmware area
// [R12] Host reads select back, then synchronises
// [R13] Host synchronises before leaving firmware area
// [R14] Host syncs, clears caches after switching back
// [R15] Vectors in RAM while firmware area selected
// [R16] Area-two transfer leaves area select alone
// [R17] Vectors off code flash when busy, no background
`ifndef FAPR_PARAMS_SVH
`define FAPR_PARAMS_SVH
`define FAPR_ADDR_W 3
`define FAPR_DATA_W 8
`define FAPR_ECC_W 4
`define FAPR_WORDS 8
`define FAPR_BLKS 2
`define FAPR_BLK_BIT 2
`define FAPR_BOOT_BLK 1'b1
`define FAPR_CLK_MHZ 40
`define FAPR_OP_TIME_NS 200
`define FAPR_OP_CYC ((`FAPR_OP_TIME_NS * `FAPR_CLK_MHZ + 999) / 1000)
`define FAPR_CNT_W 4
`define FAPR_SYNC_CYC 2
`define FAPR_SYNC_W 2
`define FAPR_AREA_CODE 1'b0
`define FAPR_AREA_FW 1'b1
`define FAPR_ERASED_DATA 8'hff
`define FAPR_ERASED_ECC 4'hf
`define FAPR_ERASED_PAR 1'b1
`define FAPR_UNDEF_MASK 8'ha5
// Arbitrary firmware content seed
`define FAPR_FW_SEED 8'h3c
`endif

// [fapr_pkg.sv]
`default_nettype none
`include "fapr_params.svh"
package fapr_pkg;
  typedef enum logic [1:0] {FAPR_OP_READ, FAPR_OP_PROG, FAPR_OP_ERASE} fapr_op_e;
  typedef enum logic [2:0] {FAPR_U_READ, FAPR_U_WRITE, FAPR_U_ERASE, FAPR_U_FWREAD,
    FAPR_U_FWXFER} fapr_uop_e;
  typedef logic [`FAPR_ADDR_W-1:0] fapr_addr_t;
  typedef logic [`FAPR_DATA_W-1:0] fapr_data_t;
  typedef logic [`FAPR_ECC_W-1:0] fapr_ecc_t;

  // Check bits; an all-ones word yields zero so erased cells never match
  function automatic fapr_ecc_t fapr_ecc(input fapr_data_t d);
    fapr_ecc = {^d[7:4], ^d[3:0], ^(d[7:6] ^ d[1:0]), ^d[5:2]};
  endfunction : fapr_ecc

  function automatic logic fapr_par(input fapr_addr_t a);
    fapr_par = ^a;
  endfunction : fapr_par

  function automatic fapr_data_t fapr_fw_word(input fapr_addr_t a);
    fapr_fw_word = `FAPR_FW_SEED ^ `FAPR_DATA_W'(a);
  endfunction : fapr_fw_word
endpackage : fapr_pkg
`default_nettype wire

// [fapr_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fapr_params.svh"
interface fapr_if;
  import fapr_pkg::*;
  logic cmdValid;
  logic cmdReady;
  fapr_op_e cmdOp;
  fapr_addr_t cmdAddr;
  fapr_data_t cmdData;
  logic lockProtDis;
  logic hvUpper;
  logic hvLower;
  logic abortOp;
  logic areaWr;
  logic areaWdata;
  logic areaSel;
  logic rspValid;
  fapr_data_t rspData;
  fapr_ecc_t rspEcc;
  logic rspPar;
  logic eccErr;
  logic ilglErr;
  logic ersErr;
  logic prgErr;
  logic hvErr;
  logic busy;
  modport dev (input cmdValid, cmdOp, cmdAddr, cmdData, lockProtDis, hvUpper, hvLower,
    abortOp, areaWr, areaWdata, output cmdReady, areaSel, rspValid, rspData, rspEcc,
    rspPar, eccErr, ilglErr, ersErr, prgErr, hvErr, busy);
  modport host (output cmdValid, cmdOp, cmdAddr, cmdData, lockProtDis, hvUpper, hvLower,
    abortOp, areaWr, areaWdata, input cmdReady, areaSel, rspValid, rspData, rspEcc,
    rspPar, eccErr, ilglErr, ersErr, prgErr, hvErr, busy);
endinterface : fapr_if
`default_nettype wire

// [fapr_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fapr_params.svh"
module fapr_device
  import fapr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic serialModePin,
  output logic serialActive,
  fapr_if.dev link
);
  typedef enum logic {FAPR_D_IDLE, FAPR_D_BUSY} fapr_dstate_e;
  fapr_dstate_e dstate_r;
  fapr_data_t memData_r [`FAPR_WORDS];
  fapr_ecc_t memEcc_r [`FAPR_WORDS];
  logic memPar_r [`FAPR_WORDS];
  logic [`FAPR_WORDS-1:0] written_r;
  logic [`FAPR_BLKS-1:0] lock_r;
  logic ser1_r, ser2_r, areaSel_r;
  fapr_op_e op_r;
  fapr_addr_t addr_r;
  fapr_data_t data_r;
  logic [`FAPR_CNT_W-1:0] cnt_r;
  logic rspValid_r, eccErr_r, ilgl_r, ers_r, prg_r, hv_r, rspPar_r;
  fapr_data_t rspData_r;
  fapr_ecc_t rspEcc_r;
  logic accept, hvOk, failNow, finish, isWr, bootHit, fwHit, dblHit, lockHit, reject;
  logic blkIn, blkCur;

  assign link.cmdReady = (dstate_r == FAPR_D_IDLE) && ce;
  assign accept = link.cmdValid && link.cmdReady;
  assign hvOk = link.hvUpper && link.hvLower;
  assign failNow = (dstate_r == FAPR_D_BUSY) && (link.abortOp || !hvOk);
  assign finish = (dstate_r == FAPR_D_BUSY) && (cnt_r == '0);
  assign blkIn = link.cmdAddr[`FAPR_BLK_BIT];
  assign blkCur = addr_r[`FAPR_BLK_BIT];
  assign isWr = link.cmdOp != FAPR_OP_READ;
  assign bootHit = isWr && (blkIn == `FAPR_BOOT_BLK) && !ser2_r; // see [R1] see [R2]
  assign fwHit = isWr && (areaSel_r == `FAPR_AREA_FW); // see [R11]
  assign dblHit = (link.cmdOp == FAPR_OP_PROG) && written_r[link.cmdAddr]; // see [R6]
  assign lockHit = isWr && lock_r[blkIn]
    && !(link.cmdOp == FAPR_OP_ERASE && link.lockProtDis); // see [R8]
  assign reject = bootHit || fwHit || dblHit || lockHit;

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      ser1_r <= 1'b0;
      ser2_r <= 1'b0;
      areaSel_r <= `FAPR_AREA_CODE;
    end
    else if (ce)
    begin
      ser1_r <= serialModePin;
      ser2_r <= ser1_r;
      if (link.areaWr)
        areaSel_r <= link.areaWdata; // see [R11]
    end

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      dstate_r <= FAPR_D_IDLE;
      op_r <= FAPR_OP_READ;
      addr_r <= '0;
      data_r <= '0;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      case (dstate_r)
        FAPR_D_IDLE:
          if (accept && isWr && !reject)
          begin
            dstate_r <= FAPR_D_BUSY;
            op_r <= link.cmdOp;
            addr_r <= link.cmdAddr;
            data_r <= link.cmdData;
            cnt_r <= `FAPR_CNT_W'(`FAPR_OP_CYC - 1);
          end
        FAPR_D_BUSY:
          if (failNow || finish)
            dstate_r <= FAPR_D_IDLE;
          else
            cnt_r <= cnt_r - 1'b1;
        default:
          dstate_r <= FAPR_D_IDLE;
      endcase
    end

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      for (int i = 0; i < `FAPR_WORDS; i++)
      begin
        memData_r[i] <= `FAPR_ERASED_DATA;
        memEcc_r[i] <= `FAPR_ERASED_ECC;
        memPar_r[i] <= `FAPR_ERASED_PAR;
      end
      written_r <= '0;
      lock_r <= '0;
    end
    else if (ce && (failNow || finish))
    begin
      if (op_r == FAPR_OP_PROG)
      begin
        // Cut short: data garbled, check bits left erased
        memData_r[addr_r] <= failNow ? (data_r ^ `FAPR_UNDEF_MASK) : data_r; // see [R5]
        if (!failNow)
        begin
          memEcc_r[addr_r] <= fapr_ecc(data_r);
          memPar_r[addr_r] <= fapr_par(addr_r);
        end
        written_r[addr_r] <= 1'b1;
      end
      else
      begin
        for (int i = 0; i < `FAPR_WORDS; i++)
          if (`FAPR_ADDR_W'(i) >> `FAPR_BLK_BIT == `FAPR_ADDR_W'(blkCur))
          begin
            memData_r[i] <= `FAPR_ERASED_DATA;
            memEcc_r[i] <= `FAPR_ERASED_ECC;
            memPar_r[i] <= `FAPR_ERASED_PAR;
            // Cut-short erase looks blank but keeps cells marked written
            if (!failNow)
              written_r[i] <= 1'b0; // see [R6]
          end
      end
      lock_r[blkCur] <= failNow; // see [R8]
    end

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      rspValid_r <= 1'b0;
      rspData_r <= '0;
      rspEcc_r <= '0;
      rspPar_r <= 1'b0;
      eccErr_r <= 1'b0;
      ilgl_r <= 1'b0;
      ers_r <= 1'b0;
      prg_r <= 1'b0;
      hv_r <= 1'b0;
    end
    else if (ce)
    begin
      rspValid_r <= 1'b0;
      if (accept)
      begin
        eccErr_r <= 1'b0;
        ilgl_r <= fwHit;
        ers_r <= (link.cmdOp == FAPR_OP_ERASE) && (bootHit || lockHit);
        prg_r <= (link.cmdOp == FAPR_OP_PROG) && (bootHit || lockHit || dblHit);
        hv_r <= 1'b0;
        rspValid_r <= !isWr || reject;
        if (!isWr && areaSel_r == `FAPR_AREA_FW)
        begin
          rspData_r <= fapr_fw_word(link.cmdAddr);
          rspEcc_r <= fapr_ecc(fapr_fw_word(link.cmdAddr));
          rspPar_r <= fapr_par(link.cmdAddr);
        end
        else if (!isWr)
        begin
          rspData_r <= memData_r[link.cmdAddr];
          rspEcc_r <= memEcc_r[link.cmdAddr];
          rspPar_r <= memPar_r[link.cmdAddr];
          eccErr_r <= memEcc_r[link.cmdAddr] != fapr_ecc(memData_r[link.cmdAddr]); // see [R3]
        end
      end
      else if (failNow)
      begin
        rspValid_r <= 1'b1;
        hv_r <= !hvOk; // see [R10]
        ers_r <= op_r == FAPR_OP_ERASE;
        prg_r <= op_r == FAPR_OP_PROG;
      end
      else if (finish)
        rspValid_r <= 1'b1;
    end

  assign link.areaSel = areaSel_r;
  assign link.busy = dstate_r == FAPR_D_BUSY;
  assign link.rspValid = rspValid_r;
  assign link.rspData = rspData_r;
  assign link.rspEcc = rspEcc_r;
  assign link.rspPar = rspPar_r;
  assign link.eccErr = eccErr_r;
  assign link.ilglErr = ilgl_r;
  assign link.ersErr = ers_r;
  assign link.prgErr = prg_r;
  assign link.hvErr = hv_r;
  assign serialActive = ser2_r;
endmodule : fapr_device
`default_nettype wire

// [fapr_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fapr_params.svh"
module fapr_host
  import fapr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic usrValid,
  input wire fapr_uop_e usrOp,
  input wire fapr_addr_t usrAddr,
  input wire fapr_data_t usrData,
  input wire logic usrHvEn,
  input wire logic usrAbort,
  input wire logic bgOk,
  output logic usrReady,
  output logic usrDone,
  output logic usrErr,
  output fapr_data_t usrRdata,
  output logic vecInRam,
  output logic cacheClr,
  output logic areaReadback,
  fapr_if.host link
);
  typedef enum logic [3:0] {
    FAPR_H_IDLE,
    FAPR_H_SEL_WR,
    FAPR_H_SEL_RD,
    FAPR_H_SEL_SYNC,
    FAPR_H_RD,
    FAPR_H_RD_W,
    FAPR_H_POST_SYNC,
    FAPR_H_ERS,
    FAPR_H_ERS_W,
    FAPR_H_PRG,
    FAPR_H_PRG_W,
    FAPR_H_DONE
  } fapr_hstate_e;

  fapr_hstate_e hstate_r;
  fapr_uop_e uop_r;
  fapr_addr_t addr_r;
  fapr_data_t data_r;
  fapr_data_t rdata_r;
  logic selTarget_r;
  logic fwSel_r;
  logic readback_r;
  logic [`FAPR_SYNC_W-1:0] syncCnt_r;
  logic [`FAPR_BLKS-1:0] undefBlk_r;
  logic abortSeen_r;
  logic hvEn_r;
  logic err_r;
  logic cacheClr_r;
  logic blk;
  logic blank;
  logic anyErr;
  logic abnormal;

  assign blk = addr_r[`FAPR_BLK_BIT];
  assign blank = (link.rspData == `FAPR_ERASED_DATA) && (link.rspEcc == `FAPR_ERASED_ECC)
    && (link.rspPar == `FAPR_ERASED_PAR); // see [R4]
  assign anyErr = link.ilglErr || link.ersErr || link.prgErr || link.hvErr;
  assign abnormal = abortSeen_r || link.abortOp || link.hvErr;

  // Command issue
  assign link.cmdValid = (hstate_r == FAPR_H_RD) || (hstate_r == FAPR_H_ERS)
    || (hstate_r == FAPR_H_PRG);
  always_comb
  begin
    case (hstate_r)
      FAPR_H_ERS: link.cmdOp = FAPR_OP_ERASE;
      FAPR_H_PRG: link.cmdOp = FAPR_OP_PROG;
      default: link.cmdOp = FAPR_OP_READ;
    endcase
  end
  assign link.cmdAddr = addr_r;
  assign link.cmdData = data_r;
  assign link.lockProtDis = undefBlk_r[blk]; // see [R8]
  assign link.hvUpper = hvEn_r;
  assign link.hvLower = hvEn_r;
  assign link.abortOp = usrAbort && link.busy;
  assign link.areaWr = hstate_r == FAPR_H_SEL_WR; // see [R11]
  assign link.areaWdata = selTarget_r;

  // User side
  assign usrReady = hstate_r == FAPR_H_IDLE;
  assign usrDone = hstate_r == FAPR_H_DONE;
  assign usrErr = err_r;
  assign usrRdata = rdata_r;
  assign cacheClr = cacheClr_r;
  assign areaReadback = readback_r;
  // Keep exception vectors off flash while it is unsafe to fetch there
  assign vecInRam = fwSel_r || (link.busy && !bgOk); // see [R15] see [R17]

  // Enables change only with the sequencer quiet
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      hvEn_r <= 1'b0;
    else if (ce && hstate_r == FAPR_H_IDLE && !link.busy)
      hvEn_r <= usrHvEn; // see [R9]

  // Abort tracking; a new request clears it, a fresh abort wins
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      abortSeen_r <= 1'b0;
    else if (ce)
    begin
      if (hstate_r == FAPR_H_IDLE && usrValid)
        abortSeen_r <= 1'b0;
      if (link.abortOp)
        abortSeen_r <= 1'b1;
    end

  // Blocks left undefined by a cut-short operation
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      undefBlk_r <= '0;
    else if (ce && link.rspValid)
    begin
      if ((hstate_r == FAPR_H_ERS_W || hstate_r == FAPR_H_PRG_W) && abnormal)
        undefBlk_r[blk] <= 1'b1; // see [R5] see [R7]
      else if (hstate_r == FAPR_H_ERS_W && !anyErr)
        undefBlk_r[blk] <= 1'b0; // see [R7]
    end

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      hstate_r <= FAPR_H_IDLE;
      uop_r <= FAPR_U_READ;
      addr_r <= '0;
      data_r <= '0;
      rdata_r <= '0;
      selTarget_r <= `FAPR_AREA_CODE;
      fwSel_r <= `FAPR_AREA_CODE;
      readback_r <= `FAPR_AREA_CODE;
      syncCnt_r <= '0;
      err_r <= 1'b0;
      cacheClr_r <= 1'b0;
    end
    else if (ce)
    begin
      cacheClr_r <= 1'b0;
      case (hstate_r)
        FAPR_H_IDLE:
          if (usrValid)
          begin
            uop_r <= usrOp;
            addr_r <= usrAddr;
            data_r <= usrData;
            err_r <= 1'b0;
            case (usrOp)
              FAPR_U_READ:
                if (undefBlk_r[usrAddr[`FAPR_BLK_BIT]])
                begin
                  err_r <= 1'b1; // see [R5]
                  hstate_r <= FAPR_H_DONE;
                end
                else
                  hstate_r <= FAPR_H_RD;
              FAPR_U_WRITE:
                hstate_r <= undefBlk_r[usrAddr[`FAPR_BLK_BIT]] ? FAPR_H_ERS
                  : FAPR_H_RD; // see [R7]
              FAPR_U_ERASE:
                hstate_r <= FAPR_H_ERS;
              FAPR_U_FWREAD:
              begin
                selTarget_r <= `FAPR_AREA_FW; // see [R11]
                hstate_r <= FAPR_H_SEL_WR;
              end
              FAPR_U_FWXFER:
                hstate_r <= FAPR_H_RD; // see [R16]
              default:
                hstate_r <= FAPR_H_DONE;
            endcase
          end
        FAPR_H_SEL_WR:
        begin
          fwSel_r <= selTarget_r;
          hstate_r <= FAPR_H_SEL_RD;
        end
        FAPR_H_SEL_RD:
        begin
          readback_r <= link.areaSel; // see [R12]
          syncCnt_r <= `FAPR_SYNC_W'(`FAPR_SYNC_CYC - 1);
          hstate_r <= FAPR_H_SEL_SYNC;
        end
        FAPR_H_SEL_SYNC:
          if (syncCnt_r != '0)
            syncCnt_r <= syncCnt_r - 1'b1; // see [R12]
          else if (selTarget_r == `FAPR_AREA_FW)
            hstate_r <= FAPR_H_RD;
          else
          begin
            cacheClr_r <= 1'b1; // see [R14]
            hstate_r <= FAPR_H_DONE;
          end
        FAPR_H_RD:
          if (link.cmdReady)
            hstate_r <= FAPR_H_RD_W;
        FAPR_H_RD_W:
          if (link.rspValid)
          begin
            if (uop_r == FAPR_U_WRITE)
              hstate_r <= blank ? FAPR_H_PRG : FAPR_H_ERS; // see [R4] see [R6]
            else
            begin
              rdata_r <= link.rspData;
              err_r <= link.eccErr || link.ilglErr;
              if (uop_r == FAPR_U_FWREAD)
              begin
                syncCnt_r <= `FAPR_SYNC_W'(`FAPR_SYNC_CYC - 1);
                hstate_r <= FAPR_H_POST_SYNC;
              end
              else
                hstate_r <= FAPR_H_DONE;
            end
          end
        FAPR_H_POST_SYNC:
          if (syncCnt_r != '0)
            syncCnt_r <= syncCnt_r - 1'b1; // see [R13]
          else
          begin
            selTarget_r <= `FAPR_AREA_CODE;
            hstate_r <= FAPR_H_SEL_WR; // see [R13]
          end
        FAPR_H_ERS:
          if (link.cmdReady)
            hstate_r <= FAPR_H_ERS_W;
        FAPR_H_ERS_W:
          if (link.rspValid)
          begin
            if (anyErr)
            begin
              err_r <= 1'b1;
              hstate_r <= FAPR_H_DONE;
            end
            else
              hstate_r <= (uop_r == FAPR_U_WRITE) ? FAPR_H_PRG : FAPR_H_DONE; // see [R6]
          end
        FAPR_H_PRG:
          if (link.cmdReady)
            hstate_r <= FAPR_H_PRG_W;
        FAPR_H_PRG_W:
          if (link.rspValid)
          begin
            err_r <= anyErr;
            hstate_r <= FAPR_H_DONE;
          end
        FAPR_H_DONE:
          hstate_r <= FAPR_H_IDLE;
        default:
          hstate_r <= FAPR_H_IDLE;
      endcase
    end
endmodule : fapr_host
`default_nettype wire

// [fapr_link_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fapr_params.svh"
module fapr_link_chk
  import fapr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serialActive,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input var fapr_op_e cmdOp,
  input wire fapr_addr_t cmdAddr,
  input wire logic hvUpper,
  input wire logic hvLower,
  input wire logic abortOp,
  input wire logic areaWr,
  input wire logic areaWdata,
  input wire logic areaSel,
  input wire logic rspValid,
  input wire fapr_data_t rspData,
  input wire fapr_ecc_t rspEcc,
  input wire logic eccErr,
  input wire logic ilglErr,
  input wire logic ersErr,
  input wire logic prgErr,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  logic opWr;
  logic hvDrop;
  assign acc = cmdValid && cmdReady;
  assign opWr = acc && cmdOp != FAPR_OP_READ;
  assign hvDrop = !(hvUpper && hvLower);
  sequence s_rd_acc; acc && cmdOp == FAPR_OP_READ && !areaSel; endsequence
  sequence s_blank; rspData == `FAPR_ERASED_DATA && rspEcc == `FAPR_ERASED_ECC; endsequence
  sequence s_full_op; $rose(busy) ##0 (busy && !abortOp && !hvDrop) [*8]; endsequence
  property p_rd_rsp; s_rd_acc |=> rspValid; endproperty
  property p_blank_ecc; s_rd_acc ##1 s_blank |-> eccErr; endproperty
  property p_boot_prot;
    opWr && cmdAddr[`FAPR_BLK_BIT] == `FAPR_BOOT_BLK && !serialActive && !areaSel
      |=> rspValid && !busy && (prgErr || ersErr);
  endproperty
  property p_fw_refuse;
    opWr && areaSel && cmdAddr[`FAPR_BLK_BIT] != `FAPR_BOOT_BLK
      |=> rspValid && ilglErr && !busy;
  endproperty
  property p_area_upd; areaWr |=> areaSel == $past(areaWdata); endproperty
  property p_abort; busy && (abortOp || hvDrop) |=> rspValid && !busy; endproperty
  property p_full_op; s_full_op |=> rspValid && !busy; endproperty
  property p_fell_rsp; $fell(busy) |-> rspValid; endproperty
  property p_one_cmd; busy |-> !cmdReady && !rspValid; endproperty
  a_rd_rsp: assert property (p_rd_rsp) else $error("read without response");
  a_blank_ecc: assert property (p_blank_ecc) else $error("blank read no ecc flag");
  a_boot_prot: assert property (p_boot_prot) else $error("boot block not protected");
  a_fw_refuse: assert property (p_fw_refuse) else $error("write in firmware area");
  a_area_upd: assert property (p_area_upd) else $error("area select not updated");
  a_abort: assert property (p_abort) else $error("abort did not end op");
  a_full_op: assert property (p_full_op) else $error("op length wrong");
  a_fell_rsp: assert property (p_fell_rsp) else $error("op end without response");
  a_one_cmd: assert property (p_one_cmd) else $error("ready while busy");
endmodule : fapr_link_chk
`default_nettype wire

// [flash_area_protection_rules_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fapr_params.svh"
module flash_area_protection_rules_tb
  import fapr_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic modeA = 1'b0;
  logic usrValid = 1'b0;
  fapr_uop_e usrOp = FAPR_U_READ;
  fapr_addr_t usrAddr = 3'h0;
  fapr_data_t usrData = 8'h00;
  logic usrHvEn = 1'b0;
  logic usrAbort = 1'b0;
  logic bgOk = 1'b1;
  logic actA, actB, areaRb, usrReady, usrDone, usrErr, vecInRam, cacheClr, sawVec, sawClr, sawRb;
  fapr_data_t usrRdata;
  int mismatches = 0;
  int nTests = 0;
  fapr_if linkA ();
  fapr_if linkB ();
  always #12.5 core_clk = ~core_clk;
  fapr_device u_fapr_device (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .serialModePin(modeA), .serialActive(actA), .link(linkA));
  fapr_device u_fapr_device_b (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .serialModePin(1'b0), .serialActive(actB), .link(linkB));
  fapr_host u_fapr_host (.core_clk(core_clk), .resetn(resetn), .ce(ce), .usrValid(usrValid),
    .usrOp(usrOp), .usrAddr(usrAddr), .usrData(usrData), .usrHvEn(usrHvEn),
    .usrAbort(usrAbort), .bgOk(bgOk), .usrReady(usrReady), .usrDone(usrDone),
    .usrErr(usrErr), .usrRdata(usrRdata), .vecInRam(vecInRam), .cacheClr(cacheClr),
    .areaReadback(areaRb), .link(linkA));
  fapr_link_chk u_fapr_link_chk (.core_clk(core_clk), .resetn(resetn), .serialActive(actB),
    .cmdValid(linkB.cmdValid), .cmdReady(linkB.cmdReady), .cmdOp(linkB.cmdOp),
    .cmdAddr(linkB.cmdAddr), .hvUpper(linkB.hvUpper), .hvLower(linkB.hvLower),
    .abortOp(linkB.abortOp), .areaWr(linkB.areaWr), .areaWdata(linkB.areaWdata),
    .areaSel(linkB.areaSel), .rspValid(linkB.rspValid), .rspData(linkB.rspData),
    .rspEcc(linkB.rspEcc), .eccErr(linkB.eccErr), .ilglErr(linkB.ilglErr),
    .ersErr(linkB.ersErr), .prgErr(linkB.prgErr), .busy(linkB.busy));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait at falling edges; also records host side flags
  task automatic waitSig(input int sel);
    logic s;
    for (int k = 0; k < 300; k++)
    begin
      @(negedge core_clk);
      s = sel == 0 ? linkB.rspValid : sel == 1 ? linkB.busy : sel == 2 ? usrDone : linkA.busy;
      sawVec |= vecInRam;
      sawClr |= cacheClr;
      sawRb |= areaRb;
      if (s === 1'b1)
        return;
    end
    chk(8'h00, 8'h01);
    close_out();
  endtask : waitSig

  // Device stays idle between ops, so the request is taken at the next edge
  task automatic dop(input fapr_op_e op, input fapr_addr_t a, input fapr_data_t d,
    input logic lp);
    @(posedge core_clk);
    linkB.cmdValid <= 1'b1;
    linkB.cmdOp <= op;
    linkB.cmdAddr <= a;
    linkB.cmdData <= d;
    linkB.lockProtDis <= lp;
    @(posedge core_clk);
    linkB.cmdValid <= 1'b0;
    waitSig(0);
  endtask : dop

  task automatic hop(input fapr_uop_e op, input fapr_addr_t a, input fapr_data_t d);
    @(posedge core_clk);
    usrValid <= 1'b1;
    usrOp <= op;
    usrAddr <= a;
    usrData <= d;
    sawVec = 1'b0;
    sawClr = 1'b0;
    sawRb = 1'b0;
    @(posedge core_clk);
    usrValid <= 1'b0;
    waitSig(2);
  endtask : hop

  function automatic logic [7:0] flg();
    return {3'h0, linkB.eccErr, linkB.ilglErr, linkB.ersErr, linkB.prgErr, linkB.hvErr};
  endfunction : flg

  task automatic areaSet(input logic v);
    @(posedge core_clk);
    linkB.areaWr <= 1'b1;
    linkB.areaWdata <= v;
    @(posedge core_clk);
    linkB.areaWr <= 1'b0;
    @(negedge core_clk);
    chk({7'h0, linkB.areaSel}, {7'h0, v});
  endtask : areaSet

  initial
  begin
    linkB.cmdValid = 1'b0;
    linkB.cmdOp = FAPR_OP_READ;
    linkB.cmdAddr = 3'h0;
    linkB.cmdData = 8'h00;
    linkB.lockProtDis = 1'b0;
    linkB.hvUpper = 1'b1;
    linkB.hvLower = 1'b1;
    linkB.abortOp = 1'b0;
    linkB.areaWr = 1'b0;
    linkB.areaWdata = 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    usrHvEn <= 1'b1;
    dop(FAPR_OP_READ, 3'h0, 8'h00, 1'b0);
    chk(linkB.rspData, 8'hff);
    chk({4'h0, linkB.rspEcc}, 8'h0f);
    chk({7'h0, linkB.rspPar}, 8'h01);
    chk(flg(), 8'h10);
    dop(FAPR_OP_PROG, 3'h4, 8'h77, 1'b0);
    chk(flg(), 8'h02);
    dop(FAPR_OP_ERASE, 3'h4, 8'h00, 1'b0);
    chk(flg(), 8'h04);
    dop(FAPR_OP_PROG, 3'h1, 8'h5a, 1'b0);
    chk(flg(), 8'h00);
    dop(FAPR_OP_PROG, 3'h1, 8'hc3, 1'b0);
    chk(flg(), 8'h02);
    $display("end blank, boot and rewrite on device");
    fork
      dop(FAPR_OP_PROG, 3'h2, 8'h33, 1'b0);
      begin
        waitSig(1);
        @(posedge core_clk);
        linkB.hvLower <= 1'b0;
      end
    join
    chk(flg(), 8'h03);
    @(posedge core_clk);
    linkB.hvLower <= 1'b1;
    dop(FAPR_OP_READ, 3'h2, 8'h00, 1'b0);
    chk(flg(), 8'h10);
    dop(FAPR_OP_PROG, 3'h3, 8'h22, 1'b0);
    chk(flg(), 8'h02);
    dop(FAPR_OP_ERASE, 3'h0, 8'h00, 1'b0);
    chk(flg(), 8'h04);
    dop(FAPR_OP_ERASE, 3'h0, 8'h00, 1'b1);
    chk(flg(), 8'h00);
    dop(FAPR_OP_PROG, 3'h2, 8'h11, 1'b0);
    chk(flg(), 8'h00);
    dop(FAPR_OP_READ, 3'h2, 8'h00, 1'b0);
    chk(linkB.rspData, 8'h11);
    $display("end voltage drop and lock");
    areaSet(`FAPR_AREA_FW);
    dop(FAPR_OP_PROG, 3'h0, 8'h01, 1'b0);
    chk(flg(), 8'h08);
    dop(FAPR_OP_READ, 3'h3, 8'h00, 1'b0);
    chk(linkB.rspData, `FAPR_FW_SEED ^ 8'h03);
    areaSet(`FAPR_AREA_CODE);
    $display("end area select on device");
    hop(FAPR_U_READ, 3'h0, 8'h00);
    chk({7'h0, usrErr}, 8'h01);
    hop(FAPR_U_WRITE, 3'h1, 8'h5a);
    chk({7'h0, usrErr}, 8'h00);
    hop(FAPR_U_WRITE, 3'h1, 8'hc3);
    chk({7'h0, usrErr}, 8'h00);
    hop(FAPR_U_READ, 3'h1, 8'h00);
    chk(usrRdata, 8'hc3);
    hop(FAPR_U_WRITE, 3'h5, 8'h66);
    chk({7'h0, usrErr}, 8'h01);
    $display("end host rewrite and boot");
    hop(FAPR_U_FWREAD, 3'h3, 8'h00);
    chk(usrRdata, `FAPR_FW_SEED ^ 8'h03);
    chk({7'h0, sawVec}, 8'h01);
    chk({7'h0, sawClr}, 8'h01);
    chk({7'h0, sawRb}, 8'h01);
    chk({7'h0, linkA.areaSel}, 8'h00);
    hop(FAPR_U_FWXFER, 3'h3, 8'h00);
    chk({7'h0, sawVec}, 8'h00);
    bgOk <= 1'b0;
    hop(FAPR_U_WRITE, 3'h0, 8'h12);
    chk({7'h0, sawVec}, 8'h01);
    bgOk <= 1'b1;
    $display("end host firmware area");
    fork
      hop(FAPR_U_WRITE, 3'h2, 8'h44);
      begin
        waitSig(3);
        @(posedge core_clk);
        usrAbort <= 1'b1;
        @(posedge core_clk);
        usrAbort <= 1'b0;
      end
    join
    chk({7'h0, usrErr}, 8'h01);
    hop(FAPR_U_READ, 3'h2, 8'h00);
    chk({7'h0, usrErr}, 8'h01);
    hop(FAPR_U_WRITE, 3'h2, 8'h44);
    chk({7'h0, usrErr}, 8'h00);
    hop(FAPR_U_READ, 3'h2, 8'h00);
    chk(usrRdata, 8'h44);
    @(posedge core_clk);
    modeA <= 1'b1;
    repeat (5) @(posedge core_clk);
    hop(FAPR_U_WRITE, 3'h6, 8'ha7);
    chk({7'h0, usrErr}, 8'h00);
    hop(FAPR_U_READ, 3'h6, 8'h00);
    chk(usrRdata, 8'ha7);
    $display("end host abort and serial path");
    close_out();
  end
endmodule : flash_area_protection_rules_tb
`default_nettype wire
